//--- pkg/camera_dsp_control_regs_defines.vh
// constants for the camera image-processor control register bank
`ifndef CAMERA_DSP_CONTROL_REGS_DEFINES_VH
`define CAMERA_DSP_CONTROL_REGS_DEFINES_VH
// ------------------------------------------------------------
// serial control bus identity
// ------------------------------------------------------------
`define DEV_ADDR_WR          8'h60
`define DEV_ADDR_RD          8'h61
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_BYPASS           8'h05
`define OFS_QUANT            8'h44
`define OFS_DIV_CTRL         8'h50
`define OFS_WIN_W            8'h51
`define OFS_WIN_H            8'h52
`define OFS_OFF_X            8'h53
`define OFS_OFF_Y            8'h54
`define OFS_SIZE_HI          8'h55
`define OFS_DP_SEL           8'h56
`define OFS_W_BIT9           8'h57
`define OFS_OUT_W            8'h5A
`define OFS_OUT_H            8'h5B
`define OFS_OUT_HI           8'h5C
`define OFS_FX_ADDR          8'h7C
`define OFS_FX_DATA          8'h7D
`define OFS_EN_B             8'h86
`define OFS_EN_C             8'h87
`define OFS_SIZE_LO          8'h8C
`define OFS_IMG_W            8'hC0
`define OFS_IMG_H            8'hC1
`define OFS_EN_MAIN          8'hC2
`define OFS_EN_A             8'hC3
`define OFS_PCLK_DIV         8'hD3
`define OFS_FORMAT           8'hDA
`define OFS_BANK             8'hFF
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_BYPASS           1'h1
`define RST_QUANT            8'h0C
`define RST_WIN_W            8'h40
`define RST_WIN_H            8'hF0
`define RST_SIZE_HI          8'h08
`define RST_OUT_W            8'h58
`define RST_OUT_H            8'h48
`define RST_EN_B             8'h0D
`define RST_EN_C             8'h50
`define RST_IMG_W            8'h80
`define RST_IMG_H            8'h60
`define RST_EN_MAIN          8'h0C
`define RST_EN_A             8'hFF
`define RST_PCLK_DIV         8'h82
`define RST_BANK             8'h00
// ------------------------------------------------------------
// field values and timing
// ------------------------------------------------------------
`define BANK_DSP             8'h00
`define FMT_RAW10            2'h1
`define PCLK_AUTO_DIV        7'h02
`endif

//--- verilog/camera_dsp_control_regs.v
// image-processor control register bank with serial slave and parallel video launch
`include "camera_dsp_control_regs_defines.vh"
module camera_dsp_control_regs (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        sd_in,
    input  wire        sc_in,
    output reg         sd_out,
    output reg         sd_oe,
    input  wire        sensor_line,
    input  wire        sensor_frame,
    input  wire [9:0]  raw_pixel,
    input  wire [15:0] dsp_pixel,
    output reg         pixel_take,
    output reg         pclk,
    output reg         line_valid,
    output reg         frame_sync,
    output reg  [9:0]  pix_out,
    output reg         dsp_bypass,
    output reg  [7:0]  quant_scale,
    output reg  [7:0]  divider_control,
    output reg  [7:0]  dp_select,
    output reg  [7:0]  module_enable_b,
    output reg  [7:0]  module_enable_c,
    output reg  [7:0]  module_enable_main,
    output reg  [7:0]  module_enable_a,
    output wire [9:0]  window_width,
    output wire [8:0]  window_height,
    output wire [10:0] offset_x,
    output wire [10:0] offset_y,
    output wire [9:0]  output_width,
    output wire [8:0]  output_height,
    output wire [3:0]  zoom_rate,
    output wire [11:0] image_width,
    output wire [10:0] image_height
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    reg  [7:0] window_width_low;
    reg  [7:0] window_height_low;
    reg  [7:0] offset_x_low;
    reg  [7:0] offset_y_low;
    reg  [7:0] size_offset_high;
    reg        width_bit9;
    reg  [7:0] out_width_low;
    reg  [7:0] out_height_low;
    reg  [7:0] out_size_high_zoom;
    reg  [3:0] effect_indirect_addr;
    reg  [5:0] size_low_bits;
    reg  [7:0] image_width_mid;
    reg  [7:0] image_height_mid;
    reg  [7:0] pixel_clock_divider;
    reg  [7:0] output_format_select;
    reg  [7:0] bank_select;
    reg  [7:0] special_effects [0:15];

    // composed fields for the processing stages
    assign window_width  = {width_bit9, size_offset_high[3], window_width_low};
    assign window_height = {size_offset_high[7], window_height_low};
    assign offset_x      = {size_offset_high[2:0], offset_x_low};
    assign offset_y      = {size_offset_high[6:4], offset_y_low};
    assign output_width  = {out_size_high_zoom[1:0], out_width_low};
    assign output_height = {out_size_high_zoom[2], out_height_low};
    assign zoom_rate     = out_size_high_zoom[7:4];
    assign image_width   = {size_low_bits[6-1], image_width_mid, size_low_bits[4:2]};
    assign image_height  = {image_height_mid, size_low_bits[1:0], 1'b0};

    // ------------------------------------------------------------
    // serial bus input synchronisers and edge detection
    // ------------------------------------------------------------
    reg sc_s1;
    reg sc_s2;
    reg sc_q;
    reg sd_s1;
    reg sd_s2;
    reg sd_q;

    // two flip-flops before any logic, a third for edges
    always @(posedge mclk) begin
        if (!rst_n) begin
            sc_s1 <= 1'b1;
            sc_s2 <= 1'b1;
            sc_q  <= 1'b1;
            sd_s1 <= 1'b1;
            sd_s2 <= 1'b1;
            sd_q  <= 1'b1;
        end else begin
            sc_s1 <= sc_in;
            sc_s2 <= sc_s1;
            sc_q  <= sc_s2;
            sd_s1 <= sd_in;
            sd_s2 <= sd_s1;
            sd_q  <= sd_s2;
        end
    end

    wire sc_rise = sc_s2 & ~sc_q;
    wire sc_fall = ~sc_s2 & sc_q;
    wire bus_start = sc_s2 & sc_q & sd_q & ~sd_s2;
    wire bus_stop  = sc_s2 & sc_q & ~sd_q & sd_s2;

    // ------------------------------------------------------------
    // serial slave state machine
    // ------------------------------------------------------------
    localparam ST_IDLE = 3'h0;
    localparam ST_ID   = 3'h1;
    localparam ST_SUB  = 3'h2;
    localparam ST_WR   = 3'h3;
    localparam ST_RD   = 3'h4;

    reg  [2:0] state;
    reg  [3:0] bit_cnt;
    reg  [7:0] shreg;
    reg  [7:0] sub_addr;
    reg        rd_req;
    reg  [7:0] rd_data;

    wire byte_done = sc_fall & (bit_cnt == 4'h8);
    wire ack_done  = sc_fall & (bit_cnt == 4'h9);
    wire id_match  = ({shreg[7:1], 1'b0} == `DEV_ADDR_WR);
    wire wr_stb    = byte_done & (state == ST_WR);

    // read mux: bank decoded live on each access
    always @* begin
        rd_data = 8'h00;
        if (sub_addr == `OFS_BANK) begin
            rd_data = bank_select;
        end else if (bank_select == `BANK_DSP) begin
            case (sub_addr)
                `OFS_BYPASS:   rd_data = {7'h00, dsp_bypass};
                `OFS_QUANT:    rd_data = quant_scale;
                `OFS_DIV_CTRL: rd_data = divider_control;
                `OFS_WIN_W:    rd_data = window_width_low;
                `OFS_WIN_H:    rd_data = window_height_low;
                `OFS_OFF_X:    rd_data = offset_x_low;
                `OFS_OFF_Y:    rd_data = offset_y_low;
                `OFS_SIZE_HI:  rd_data = size_offset_high;
                `OFS_DP_SEL:   rd_data = dp_select;
                `OFS_W_BIT9:   rd_data = {width_bit9, 7'h00};
                `OFS_OUT_W:    rd_data = out_width_low;
                `OFS_OUT_H:    rd_data = out_height_low;
                `OFS_OUT_HI:   rd_data = out_size_high_zoom;
                `OFS_FX_ADDR:  rd_data = {4'h0, effect_indirect_addr};
                `OFS_FX_DATA:  rd_data = special_effects[effect_indirect_addr];
                `OFS_EN_B:     rd_data = module_enable_b;
                `OFS_EN_C:     rd_data = module_enable_c;
                `OFS_SIZE_LO:  rd_data = {2'h0, size_low_bits};
                `OFS_IMG_W:    rd_data = image_width_mid;
                `OFS_IMG_H:    rd_data = image_height_mid;
                `OFS_EN_MAIN:  rd_data = module_enable_main;
                `OFS_EN_A:     rd_data = module_enable_a;
                `OFS_PCLK_DIV: rd_data = pixel_clock_divider;
                `OFS_FORMAT:   rd_data = output_format_select;
                default:       rd_data = 8'h00;
            endcase
        end
    end

    // bit shifting, acknowledge and read-out on the clock line edges
    always @(posedge mclk) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            bit_cnt  <= 4'h0;
            shreg    <= 8'h00;
            sub_addr <= 8'h00;
            rd_req   <= 1'b0;
            sd_out   <= 1'b0;
            sd_oe    <= 1'b0;
        end else if (bus_start) begin
            state   <= ST_ID;
            bit_cnt <= 4'h0;
            sd_oe   <= 1'b0;
        end else if (bus_stop) begin
            state   <= ST_IDLE;
            sd_oe   <= 1'b0;
        end else if (state == ST_RD) begin
            if (sc_fall) begin
                if (bit_cnt < 4'h7) begin
                    shreg   <= {shreg[6:0], 1'b0};
                    sd_oe   <= ~shreg[6];
                    bit_cnt <= bit_cnt + 4'h1;
                end else begin
                    sd_oe <= 1'b0;                                        // master answers no-ack
                    state <= ST_IDLE;
                end
            end
        end else if (state != ST_IDLE) begin
            if (sc_rise && bit_cnt < 4'h8) begin
                shreg   <= {shreg[6:0], sd_s2};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_done) begin
                bit_cnt <= 4'h9;
                if (state == ST_ID) begin
                    if (id_match) begin
                        rd_req <= shreg[0];
                        sd_oe  <= 1'b1;
                    end else begin
                        state <= ST_IDLE;
                    end
                end else begin
                    if (state == ST_SUB) begin
                        sub_addr <= shreg;
                    end
                    sd_oe <= 1'b1;
                end
            end else if (ack_done) begin
                bit_cnt <= 4'h0;
                sd_oe   <= 1'b0;
                case (state)
                    ST_ID: begin
                        if (rd_req) begin
                            state <= ST_RD;
                            shreg <= rd_data;
                            sd_oe <= ~rd_data[7];
                        end else begin
                            state <= ST_SUB;
                        end
                    end
                    ST_SUB:  state <= ST_WR;
                    default: state <= ST_WR;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // register file writes
    // ------------------------------------------------------------
    wire bank_dsp = (bank_select == `BANK_DSP);
    wire wr_dsp   = wr_stb & bank_dsp;

    // writable registers of the image-processor bank
    always @(posedge mclk) begin
        if (!rst_n) begin
            bank_select          <= `RST_BANK;
            dsp_bypass           <= `RST_BYPASS;
            quant_scale          <= `RST_QUANT;
            divider_control      <= 8'h00;
            window_width_low     <= `RST_WIN_W;
            window_height_low    <= `RST_WIN_H;
            offset_x_low         <= 8'h00;
            offset_y_low         <= 8'h00;
            size_offset_high     <= `RST_SIZE_HI;
            dp_select            <= 8'h00;
            width_bit9           <= 1'b0;
            out_width_low        <= `RST_OUT_W;
            out_height_low       <= `RST_OUT_H;
            out_size_high_zoom   <= 8'h00;
            effect_indirect_addr <= 4'h0;
            module_enable_b      <= `RST_EN_B;
            module_enable_c      <= `RST_EN_C;
            size_low_bits        <= 6'h00;
            image_width_mid      <= `RST_IMG_W;
            image_height_mid     <= `RST_IMG_H;
            module_enable_main   <= `RST_EN_MAIN;
            module_enable_a      <= `RST_EN_A;
            pixel_clock_divider  <= `RST_PCLK_DIV;
            output_format_select <= 8'h00;
        end else if (wr_stb && sub_addr == `OFS_BANK) begin
            bank_select <= shreg;
        end else if (wr_dsp) begin
            case (sub_addr)
                `OFS_BYPASS:   dsp_bypass           <= shreg[0];
                `OFS_QUANT:    quant_scale          <= shreg;
                `OFS_DIV_CTRL: divider_control      <= shreg;
                `OFS_WIN_W:    window_width_low     <= shreg;
                `OFS_WIN_H:    window_height_low    <= shreg;
                `OFS_OFF_X:    offset_x_low         <= shreg;
                `OFS_OFF_Y:    offset_y_low         <= shreg;
                `OFS_SIZE_HI:  size_offset_high     <= shreg;
                `OFS_DP_SEL:   dp_select            <= shreg;
                `OFS_W_BIT9:   width_bit9           <= shreg[7];
                `OFS_OUT_W:    out_width_low        <= shreg;
                `OFS_OUT_H:    out_height_low       <= shreg;
                `OFS_OUT_HI:   out_size_high_zoom   <= shreg;
                `OFS_FX_ADDR:  effect_indirect_addr <= shreg[3:0];
                `OFS_EN_B:     module_enable_b      <= shreg;
                `OFS_EN_C:     module_enable_c      <= shreg;
                `OFS_SIZE_LO:  size_low_bits        <= shreg[5:0];
                `OFS_IMG_W:    image_width_mid      <= shreg;
                `OFS_IMG_H:    image_height_mid     <= shreg;
                `OFS_EN_MAIN:  module_enable_main   <= shreg;
                `OFS_EN_A:     module_enable_a      <= shreg;
                `OFS_PCLK_DIV: pixel_clock_divider  <= shreg;
                `OFS_FORMAT:   output_format_select <= shreg;
                default:       bank_select          <= bank_select;
            endcase
        end
    end

    // effect table behind the indirect data port, one entry per index
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_fx
            always @(posedge mclk) begin
                if (!rst_n) begin
                    special_effects[gi] <= 8'h00;
                end else if (wr_dsp && sub_addr == `OFS_FX_DATA && effect_indirect_addr == gi) begin
                    special_effects[gi] <= shreg;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // pixel clock generation
    // ------------------------------------------------------------
    wire       fmt_jpeg  = output_format_select[4];
    wire       fmt_y8    = output_format_select[6];
    wire       fmt_swap  = output_format_select[0];
    wire       line_valid_vs   = output_format_select[1];
    wire       raw_path  = dsp_bypass | (output_format_select[3:2] == `FMT_RAW10);
    wire [6:0] div_field = pixel_clock_divider[7] ? `PCLK_AUTO_DIV : pixel_clock_divider[6:0];
    wire [6:0] div_base  = (div_field == 7'h00) ? 7'h01 : div_field;
    wire [7:0] half_per  = raw_path ? {div_base, 1'b0} : {1'b0, div_base};

    reg  [7:0] pc_cnt;
    wire       pc_wrap  = (pc_cnt >= half_per - 8'h01);
    wire       pc_fall  = pc_wrap & pclk;

    // half-period counter toggles the pixel clock
    always @(posedge mclk) begin
        if (!rst_n) begin
            pc_cnt <= 8'h00;
            pclk   <= 1'b0;
        end else if (pc_wrap) begin
            pc_cnt <= 8'h00;
            pclk   <= ~pclk;
        end else begin
            pc_cnt <= pc_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // parallel video launch
    // ------------------------------------------------------------
    reg        byte_phase;
    reg  [7:0] second_byte;
    wire       next_line = (fmt_jpeg & line_valid_vs) ? sensor_frame : sensor_line;

    // everything changes together with the pixel clock falling, except pixel_take, which drops again one cycle later
    always @(posedge mclk) begin
        if (!rst_n) begin
            line_valid  <= 1'b0;
            frame_sync  <= 1'b0;
            pix_out     <= 10'h000;
            byte_phase  <= 1'b0;
            second_byte <= 8'h00;
            pixel_take  <= 1'b0;
        end else begin
            pixel_take <= 1'b0;
            if (pc_fall) begin
                line_valid <= next_line;
                frame_sync <= sensor_frame;
                if (!next_line) begin
                    byte_phase <= 1'b0;
                    pix_out    <= 10'h000;
                end else if (raw_path) begin
                    pix_out    <= raw_pixel;
                    pixel_take <= 1'b1;
                end else if (fmt_y8) begin
                    pix_out    <= {2'h0, dsp_pixel[15:8]};
                    pixel_take <= 1'b1;
                end else if (!byte_phase) begin
                    byte_phase  <= 1'b1;
                    pix_out     <= {2'h0, fmt_swap ? dsp_pixel[7:0] : dsp_pixel[15:8]};
                    second_byte <= fmt_swap ? dsp_pixel[15:8] : dsp_pixel[7:0];
                    pixel_take  <= 1'b1;
                end else begin
                    byte_phase <= 1'b0;
                    pix_out    <= {2'h0, second_byte};
                end
            end
        end
    end

endmodule

//--- tb/camera_dsp_control_regs_checker.sv
// assertion checker on the control register bank ports
module camera_dsp_control_regs_checker (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        sc_in,
    input wire logic        sd_oe,
    input wire logic        pclk,
    input wire logic        line_valid,
    input wire logic        frame_sync,
    input wire logic        pixel_take,
    input wire logic        dsp_bypass,
    input wire logic [9:0]  raw_pixel,
    input wire logic [9:0]  pix_out,
    input wire logic [7:0]  quant_scale,
    input wire logic [11:0] image_width
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_fall; $fell(pclk); endsequence
    // video outputs move only with a pixel clock fall
    property p_lv; $changed(line_valid) |-> s_fall; endproperty
    a_lv: assert property (p_lv) else $error("line valid off a fall");
    property p_fs; $changed(frame_sync) |-> s_fall; endproperty
    a_fs: assert property (p_fs) else $error("frame sync off a fall");
    property p_pix; $changed(pix_out) |-> s_fall; endproperty
    a_pix: assert property (p_pix) else $error("pixel data off a fall");
    property p_take; pixel_take |-> s_fall ##0 line_valid ##1 !pixel_take; endproperty
    a_take: assert property (p_take) else $error("pixel take outside a launch");
    property p_raw; $past(dsp_bypass) && line_valid && $fell(pclk) |-> pix_out == $past(raw_pixel); endproperty
    a_raw: assert property (p_raw) else $error("bypass data not raw");
    // data line drive moves with the bus clock low and stands a phase
    property p_oe; $changed(sd_oe) |-> !sc_in; endproperty
    a_oe: assert property (p_oe) else $error("drive moved with clock high");
    property p_oe_hold; $rose(sd_oe) |=> sd_oe [*8]; endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("drive too short");
    property p_rst; disable iff (1'b0) !rst_n |=> quant_scale == 8'h0C && image_width == 12'h400; endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");
endmodule
bind camera_dsp_control_regs camera_dsp_control_regs_checker u_checker (
    .mclk(mclk), .rst_n(rst_n), .sc_in(sc_in), .sd_oe(sd_oe), .pclk(pclk), .line_valid(line_valid),
    .frame_sync(frame_sync), .pixel_take(pixel_take), .dsp_bypass(dsp_bypass), .raw_pixel(raw_pixel),
    .pix_out(pix_out), .quant_scale(quant_scale), .image_width(image_width));

//--- tb/camera_dsp_control_regs_partner.sv
// pixel source and capture model on the video side
module camera_dsp_control_regs_partner (
    input  wire logic        mclk,
    input  wire logic        pclk,
    input  wire logic        pixel_take,
    input  wire logic        line_valid,
    input  wire logic        frame_sync,
    input  wire logic [9:0]  pix_out,
    output logic             sensor_line,
    output logic             sensor_frame,
    output logic      [9:0]  raw_pixel,
    output logic      [15:0] dsp_pixel,
    output logic      [7:0]  first_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] ph = 12'h000;
    logic [6:0]  cnt = 7'h00;
    logic        pclk_d = 1'b0, lv_d = 1'b0, seen = 1'b0;
    // a line every 256 cycles, frame pulse in the first 256 of 4096
    assign sensor_frame = (ph[11:8] == 4'h0);
    assign sensor_line  = ph[7] & ~sensor_frame;
    assign dsp_pixel    = {1'b1, cnt, 1'b0, cnt}; // high byte marked by bit 7
    assign raw_pixel    = {3'h4, cnt}; // raw low byte has bit 7 clear
    // step the pixel on each take, keep the first byte of a line
    always @(posedge mclk) begin
        ph <= ph + 12'h001;
        pclk_d <= pclk;
        cnt <= cnt + {6'h00, pixel_take};
        seen <= seen | frame_sync;
        if (pclk & ~pclk_d) begin
            lv_d <= line_valid;
            if (line_valid & ~lv_d & seen) begin
                first_byte <= pix_out[7:0];
            end
        end
    end
endmodule

//--- tb/camera_dsp_control_regs_tb_top.sv
// self-checking bench for the camera control register bank
`include "camera_dsp_control_regs_defines.vh"
module camera_dsp_control_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0, rst_n = 1'b0, sc_in = 1'b1, sd_m = 1'b1, ack;
    logic [7:0]  d;
    int          n_errors = 0, num_checks = 0, cycles = 0;
    wire         sd_oe, pixel_take, pclk, line_valid, frame_sync, sensor_line, sensor_frame;
    wire  [9:0]  raw_pixel, pix_out, window_width, output_width;
    wire  [15:0] dsp_pixel;
    wire  [7:0]  first_byte;
    wire  [3:0]  zoom_rate;
    wire  [8:0]  window_height, output_height;
    wire  [10:0] offset_x;
    wire         sd_in = sd_m & ~sd_oe; // open drain line with pull-up
    localparam logic [15:0] RT [19] = '{16'h0501, 16'h440C, 16'h5140, 16'h52F0, 16'h5508, 16'h5A58, 16'h5B48,
        16'h860D, 16'h8750, 16'hC080, 16'hC160, 16'hC20C, 16'hC3FF, 16'hD382, 16'hFF00, 16'h7D00, 16'h0600,
        16'h5000, 16'hDA00};
    camera_dsp_control_regs u_camera_dsp_control_regs (.mclk, .rst_n, .sd_in, .sc_in, .sd_out(), .sd_oe,
        .sensor_line, .sensor_frame, .raw_pixel, .dsp_pixel, .pixel_take, .pclk, .line_valid, .frame_sync,
        .pix_out, .dsp_bypass(), .quant_scale(), .divider_control(), .dp_select(), .module_enable_b(),
        .module_enable_c(), .module_enable_main(), .module_enable_a(), .window_width, .window_height,
        .offset_x, .offset_y(), .output_width, .output_height, .zoom_rate, .image_width(), .image_height());
    camera_dsp_control_regs_partner u_camera_dsp_control_regs_partner (.mclk, .pclk, .pixel_take,
        .line_valid, .frame_sync, .pix_out, .sensor_line, .sensor_frame, .raw_pixel, .dsp_pixel, .first_byte);
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin n_errors++; give_verdict; end
    end
    task cyc(input int n); repeat (n) @(posedge mclk); endtask
    task fin(input string t); $display("test %s done", t); endtask
    task chk(input string nm, input logic [11:0] e, g);
        num_checks++;
        if (g !== e) begin n_errors++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end
    endtask
    // pixel clock period in system clocks, measured between two rises
    task per(input logic [11:0] e);
        longint t;
        @(posedge pclk);
        t = $time;
        @(posedge pclk);
        chk("pclk period", e, 12'(($time - t) / 10));
    endtask
    // one bus bit: data set while the clock is low, line sampled mid-high
    task pb(input logic b, output logic s);
        cyc(2); sd_m <= b; cyc(8); sc_in <= 1'b1; cyc(5); s = sd_in; cyc(5); sc_in <= 1'b0;
    endtask
    task xb(input logic [7:0] v, output logic [7:0] r, output logic k);
        for (int i = 7; i >= 0; i--) pb(v[i], r[i]);
        pb(1'b1, k);
    endtask
    task go; sd_m <= 1'b1; cyc(3); sc_in <= 1'b1; cyc(10); sd_m <= 1'b0; cyc(10); sc_in <= 1'b0; endtask
    task stop; cyc(2); sd_m <= 1'b0; cyc(8); sc_in <= 1'b1; cyc(10); sd_m <= 1'b1; cyc(10); endtask
    task wr(input logic [7:0] o, v);
        logic [7:0] r;
        logic k0, k1, k2;
        go; xb(`DEV_ADDR_WR, r, k0); xb(o, r, k1); xb(v, r, k2); stop;
        chk("write ack", 12'h000, {9'h000, k0, k1, k2});
    endtask
    task rc(input logic [7:0] o, e);
        logic [7:0] r;
        logic k0, k1, k2;
        go; xb(`DEV_ADDR_WR, r, k0); xb(o, r, k1); stop; go; xb(`DEV_ADDR_RD, r, k2); xb(8'hFF, r, ack); stop;
        chk("read ack", 12'h000, {9'h000, k0, k1, k2});
        chk($sformatf("register %h", o), {4'h0, e}, {4'h0, r});
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        cyc(4);
        per(12'h008);
        foreach (RT[i]) rc(RT[i][15:8], RT[i][7:0]);
        fin("reset values");
        wr(8'h44, 8'hA5); rc(8'h44, 8'hA5);
        wr(8'h51, 8'h7F); wr(8'h55, 8'hFF); wr(8'h57, 8'h80); wr(8'h5C, 8'hA7);
        chk("window width", 12'h37F, {2'h0, window_width});
        chk("output width", 12'h358, {2'h0, output_width});
        chk("zoom rate", 12'h00A, {8'h00, zoom_rate});
        chk("window height", 12'h1F0, {3'h0, window_height});
        chk("offset x", 12'h700, {1'h0, offset_x});
        chk("output height", 12'h148, {3'h0, output_height});
        wr(8'h50, 8'hC9); rc(8'h50, 8'hC9);
        fin("sizes");
        go; xb(8'h62, d, ack); stop;
        chk("foreign id ack", 12'h001, {11'h000, ack});
        fin("device id");
        wr(8'hFF, 8'h01); rc(8'h44, 8'h00); wr(8'h44, 8'h33);
        wr(8'hFF, 8'h00); rc(8'h44, 8'hA5);
        fin("bank select");
        wr(8'h7C, 8'h03); wr(8'h7D, 8'h5A); wr(8'h7C, 8'h04); rc(8'h7D, 8'h00);
        wr(8'h7C, 8'h03); rc(8'h7D, 8'h5A);
        fin("indirect access");
        chk("raw first byte", 12'h000, {11'h000, first_byte[7]});
        wr(8'h05, 8'h00); cyc(1000);
        chk("first byte high", 12'h001, {11'h000, first_byte[7]});
        per(12'h004);
        wr(8'hDA, 8'h01); cyc(1000);
        chk("first byte low", 12'h000, {11'h000, first_byte[7]});
        wr(8'hDA, 8'h41); cyc(1000);
        chk("luma only first byte", 12'h001, {11'h000, first_byte[7]});
        fin("byte order");
        wr(8'hD3, 8'h03);
        per(12'h006);
        fin("pixel clock");
        wr(8'hDA, 8'h12);
        @(posedge sensor_frame);
        cyc(10);
        chk("line valid mirrors frame", 12'h001, {11'h000, line_valid});
        fin("frame mode");
        give_verdict;
    end
endmodule
